// ### rtl/pmi_port_mac_if_cfg.v
// Port MAC options and external interface configuration, top level
`timescale 1ns/10ps
`default_nettype none
`include "pmi_defines.vh"

module pmi_port_mac_if_cfg
(
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  // Register access
  input  wire [15:0] reg_addr_i,
  input  wire        reg_wr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_rdata_o,
  output reg         reg_rvalid_o,
  // Configuration straps of port 6
  input  wire        speed_strap_pin_i,
  input  wire        clock_role_strap_pin_i,
  input  wire [1:0]  interface_type_strap_pins_i,
  // Companion 10/100 bit of port 6
  input  wire        speed_100_i,
  // Port 6 interface control
  output reg         if_rgmii_o,
  output reg         if_rmii_o,
  output reg         if_mii_o,
  output reg  [1:0]  link_speed_o,
  output reg         receive_clock_internal_delay_o,
  output reg         transmit_clock_internal_delay_o,
  output reg         mii_clk_drive_o,
  output reg         rxc_o,
  output reg         rxc_oe_o,
  // Per-port MAC control, bit 0 is port 1
  input  wire [6:0]  full_duplex_i,
  output reg  [6:0]  storm_protect_o,
  output reg  [6:0]  back_pressure_o,
  // Per-port receive verdict
  input  wire [6:0]  rx_done_i,
  input  wire [6:0]  rx_crc_err_i,
  input  wire [6:0]  rx_is_fc_i,
  input  wire [97:0] rx_len_i,
  input  wire        fc_filter_dis_i,
  output reg  [6:0]  rx_verdict_o,
  output reg  [6:0]  rx_drop_o,
  output reg  [6:0]  rx_mirror_only_o
);

  wire [3:0]  port_num;
  wire [11:0] reg_off;
  wire        port_ok;
  wire [2:0]  pidx;
  wire [55:0] frame_rd_all;
  wire [55:0] flow_rd_all;
  wire [6:0]  storm_all;
  wire [6:0]  jumbo_all;
  wire [6:0]  bp_all;
  wire [6:0]  pass_all;
  wire        xc6_wr;
  wire        xc7_wr;
  wire [7:0]  xc6_rd;
  wire [7:0]  xc7_rd;
  wire        xc6_speed;
  wire        xc6_rxdly;
  wire        xc6_txdly;
  wire        xc6_role;
  wire [1:0]  xc6_type;
  wire        is_rgmii;
  wire        is_rmii;
  wire        is_mii;
  reg  [7:0]  rd_mux;
  reg  [1:0]  refclk_cnt_reg;
  reg  [1:0]  refclk_cnt_next;
  reg         rxc_next;

  localparam integer REF_LAST_I = `PMI_REF_HALF_CYC - 1;
  localparam [1:0]   REF_LAST   = REF_LAST_I[1:0];

  assign port_num = reg_addr_i[`PMI_PORT_MSB:`PMI_PORT_LSB];
  assign reg_off  = reg_addr_i[`PMI_OFF_MSB:0];
  assign port_ok  = (port_num >= `PMI_FIRST_PORT) && (port_num <= `PMI_LAST_PORT);
  assign pidx     = port_num[2:0] - 3'h1;

  // Per-port option copies and receive verdicts
  genvar gi;
  generate
    for (gi = 0; gi < `PMI_NUM_PORTS; gi = gi + 1)
    begin : g_port
      localparam integer PNUM_I = gi + 1;
      localparam [3:0]   PNUM   = PNUM_I[3:0];
      wire                  wr_frame;
      wire                  wr_flow;
      wire [`PMI_LEN_W-1:0] len;
      wire [`PMI_LEN_W-1:0] limit;
      wire                  bad;

      assign wr_frame = reg_wr_i && (port_num == PNUM) && (reg_off == `PMI_OFF_FRAME_OPTS);
      assign wr_flow  = reg_wr_i && (port_num == PNUM) && (reg_off == `PMI_OFF_FLOW_OPTS);

      pmi_frame_opts u_opts
      (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .wr_frame_i (wr_frame),
        .wr_flow_i  (wr_flow),
        .wdata_i    (reg_wdata_i),
        .storm_reg  (storm_all[gi]),
        .jumbo_reg  (jumbo_all[gi]),
        .bp_reg     (bp_all[gi]),
        .pass_reg   (pass_all[gi]),
        .frame_rd_o (frame_rd_all[gi*8 +: 8]),
        .flow_rd_o  (flow_rd_all[gi*8 +: 8])
      );

      assign len   = rx_len_i[gi*`PMI_LEN_W +: `PMI_LEN_W];
      assign limit = jumbo_all[gi] ? `PMI_JUMBO_PAYLOAD : `PMI_STD_PAYLOAD;
      assign bad   = rx_crc_err_i[gi] || (len > limit) || (len < `PMI_MIN_PAYLOAD);

      always @(posedge ref_clk_i)
      begin
        if (!rst_n_i)
        begin
          storm_protect_o[gi]  <= 1'b0;
          back_pressure_o[gi]  <= 1'b0;
          rx_verdict_o[gi]     <= 1'b0;
          rx_drop_o[gi]        <= 1'b0;
          rx_mirror_only_o[gi] <= 1'b0;
        end
        else
        begin
          storm_protect_o[gi] <= storm_all[gi];
          back_pressure_o[gi] <= bp_all[gi] && !full_duplex_i[gi];
          rx_verdict_o[gi]    <= rx_done_i[gi];
          if (rx_done_i[gi])
          begin
            if (rx_is_fc_i[gi] && !fc_filter_dis_i)
            begin
              // Flow control frames filtered whatever pass-all says
              rx_drop_o[gi]        <= 1'b1;
              rx_mirror_only_o[gi] <= 1'b0;
            end
            else if (bad)
            begin
              rx_drop_o[gi]        <= !pass_all[gi];
              rx_mirror_only_o[gi] <= pass_all[gi];
            end
            else
            begin
              rx_drop_o[gi]        <= 1'b0;
              rx_mirror_only_o[gi] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // External interface configuration, port 6 strapped
  assign xc6_wr = reg_wr_i && (port_num == `PMI_EXT_PORT_A) && (reg_off == `PMI_OFF_XMII_CFG);
  assign xc7_wr = reg_wr_i && (port_num == `PMI_EXT_PORT_B) && (reg_off == `PMI_OFF_XMII_CFG);

  pmi_xmii_cfg #(.STRAPPED(1)) u_xc6
  (
    .ref_clk_i     (ref_clk_i),
    .rst_n_i       (rst_n_i),
    .wr_i          (xc6_wr),
    .wdata_i       (reg_wdata_i),
    .speed_strap_i (speed_strap_pin_i),
    .role_strap_i  (clock_role_strap_pin_i),
    .type_strap_i  (interface_type_strap_pins_i),
    .speed_reg     (xc6_speed),
    .rxdly_reg     (xc6_rxdly),
    .txdly_reg     (xc6_txdly),
    .role_reg      (xc6_role),
    .type_reg      (xc6_type),
    .rd_o          (xc6_rd)
  );

  // Port 7 copy is storage only; its speed, role and type have no effect
  pmi_xmii_cfg #(.STRAPPED(0)) u_xc7
  (
    .ref_clk_i     (ref_clk_i),
    .rst_n_i       (rst_n_i),
    .wr_i          (xc7_wr),
    .wdata_i       (reg_wdata_i),
    .speed_strap_i (1'b0),
    .role_strap_i  (1'b0),
    .type_strap_i  (2'h0),
    .speed_reg     (),
    .rxdly_reg     (),
    .txdly_reg     (),
    .role_reg      (),
    .type_reg      (),
    .rd_o          (xc7_rd)
  );

  assign is_rgmii = (xc6_type == `PMI_IF_RGMII);
  assign is_rmii  = (xc6_type == `PMI_IF_RMII);
  assign is_mii   = xc6_type[1];

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rd_mux = `PMI_RD_IDLE;
    if (port_ok)
    begin
      if (reg_off == `PMI_OFF_FRAME_OPTS)
        rd_mux = frame_rd_all[{pidx, 3'h0} +: 8];
      else if (reg_off == `PMI_OFF_FLOW_OPTS)
        rd_mux = flow_rd_all[{pidx, 3'h0} +: 8];
      else if ((reg_off == `PMI_OFF_XMII_CFG) && (port_num == `PMI_EXT_PORT_A))
        rd_mux = xc6_rd;
      else if ((reg_off == `PMI_OFF_XMII_CFG) && (port_num == `PMI_EXT_PORT_B))
        rd_mux = xc7_rd;
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o  <= `PMI_RD_IDLE;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end

  // Interface mode, speed and clock-delay controls of port 6
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      if_rgmii_o                      <= 1'b0;
      if_rmii_o                       <= 1'b0;
      if_mii_o                        <= 1'b0;
      link_speed_o                    <= `PMI_SPD_10;
      receive_clock_internal_delay_o  <= 1'b0;
      transmit_clock_internal_delay_o <= 1'b0;
      mii_clk_drive_o                 <= 1'b0;
    end
    else
    begin
      if_rgmii_o <= is_rgmii;
      if_rmii_o  <= is_rmii;
      if_mii_o   <= is_mii;
      if (is_rgmii && !xc6_speed)
        link_speed_o <= `PMI_SPD_1000;
      else if (speed_100_i)
        link_speed_o <= `PMI_SPD_100;
      else
        link_speed_o <= `PMI_SPD_10;
      // Pad delay cells give the 1.5 ns minimum; logic only enables them
      receive_clock_internal_delay_o  <= is_rgmii && xc6_rxdly;
      transmit_clock_internal_delay_o <= is_rgmii && xc6_txdly;
      mii_clk_drive_o                 <= is_mii && !xc6_role;
    end
  end

  // RMII reference clock out of RXC when the port makes it
  always @*
  begin
    refclk_cnt_next = refclk_cnt_reg;
    rxc_next        = rxc_o;
    if (is_rmii && !xc6_role)
    begin
      if (refclk_cnt_reg == REF_LAST)
      begin
        refclk_cnt_next = 2'h0;
        rxc_next        = !rxc_o;
      end
      else
        refclk_cnt_next = refclk_cnt_reg + 2'h1;
    end
    else
    begin
      refclk_cnt_next = 2'h0;
      rxc_next        = 1'b0;
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      refclk_cnt_reg <= 2'h0;
      rxc_o          <= 1'b0;
      rxc_oe_o       <= 1'b0;
    end
    else
    begin
      refclk_cnt_reg <= refclk_cnt_next;
      rxc_o          <= rxc_next;
      rxc_oe_o       <= is_rmii && !xc6_role;
    end
  end

endmodule // pmi_port_mac_if_cfg

`default_nettype wire

// ### rtl/pmi_defines.vh
// Constants for the port MAC and external interface configuration block
`ifndef PMI_DEFINES_VH
`define PMI_DEFINES_VH

// Register address split: port number in the top nibble, offset below
`define PMI_ADDR_W          16
`define PMI_PORT_MSB        15
`define PMI_PORT_LSB        12
`define PMI_OFF_MSB         11
`define PMI_NUM_PORTS       7
`define PMI_FIRST_PORT      4'h1
`define PMI_LAST_PORT       4'h7
`define PMI_EXT_PORT_A      4'h6
`define PMI_EXT_PORT_B      4'h7

// Register offsets
`define PMI_OFF_XMII_CFG    12'h301
`define PMI_OFF_FRAME_OPTS  12'h400
`define PMI_OFF_FLOW_OPTS   12'h401

// External port interface configuration fields
`define PMI_XC_SPEED_BIT    6
`define PMI_XC_RXDLY_BIT    4
`define PMI_XC_TXDLY_BIT    3
`define PMI_XC_ROLE_BIT     2
`define PMI_XC_TYPE_MSB     1
`define PMI_XC_TYPE_LSB     0

// Frame and flow option fields
`define PMI_FO_STORM_BIT    1
`define PMI_FO_JUMBO_BIT    0
`define PMI_FL_BP_BIT       3
`define PMI_FL_PASS_BIT     0

// Reset values
`define PMI_XC_RXDLY_RST    1'b0
`define PMI_XC_TXDLY_RST    1'b1
`define PMI_XC_P7_SPEED_RST 1'b0
`define PMI_XC_P7_ROLE_RST  1'b0
`define PMI_XC_P7_TYPE_RST  2'h0
`define PMI_FO_STORM_RST    1'b0
`define PMI_FO_JUMBO_RST    1'b0
`define PMI_FL_BP_RST       1'b0
`define PMI_FL_PASS_RST     1'b0
`define PMI_RD_IDLE         8'h00

// Interface type and speed codes
`define PMI_IF_RGMII        2'h0
`define PMI_IF_RMII         2'h1
`define PMI_SPD_10          2'h0
`define PMI_SPD_100         2'h1
`define PMI_SPD_1000        2'h2

// Payload limits in bytes
`define PMI_LEN_W           14
`define PMI_STD_PAYLOAD     14'h05DC
`define PMI_JUMBO_PAYLOAD   14'h2328
`define PMI_MIN_PAYLOAD     14'h002E

// Timing
`define PMI_CORE_CLK_MHZ    200
`define PMI_RMII_REF_MHZ    50
`define PMI_REF_HALF_CYC    (`PMI_CORE_CLK_MHZ / (2 * `PMI_RMII_REF_MHZ))
`define PMI_RGMII_ID_MIN_PS 1500

`endif

// ### rtl/pmi_frame_opts.v
// Per-port frame and flow option registers
`timescale 1ns/10ps
`default_nettype none
`include "pmi_defines.vh"

module pmi_frame_opts
(
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  input  wire       wr_frame_i,
  input  wire       wr_flow_i,
  input  wire [7:0] wdata_i,
  output reg        storm_reg,
  output reg        jumbo_reg,
  output reg        bp_reg,
  output reg        pass_reg,
  output wire [7:0] frame_rd_o,
  output wire [7:0] flow_rd_o
);

  // Only documented bits are writable; reserved bits stay at zero
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      storm_reg <= `PMI_FO_STORM_RST;
      jumbo_reg <= `PMI_FO_JUMBO_RST;
      bp_reg    <= `PMI_FL_BP_RST;
      pass_reg  <= `PMI_FL_PASS_RST;
    end
    else
    begin
      if (wr_frame_i)
      begin
        storm_reg <= wdata_i[`PMI_FO_STORM_BIT];
        jumbo_reg <= wdata_i[`PMI_FO_JUMBO_BIT];
      end
      if (wr_flow_i)
      begin
        bp_reg   <= wdata_i[`PMI_FL_BP_BIT];
        pass_reg <= wdata_i[`PMI_FL_PASS_BIT];
      end
    end
  end

  assign frame_rd_o = {6'h00, storm_reg, jumbo_reg};
  assign flow_rd_o  = {4'h0, bp_reg, 2'h0, pass_reg};

endmodule // pmi_frame_opts

`default_nettype wire

// ### rtl/pmi_xmii_cfg.v
// External port interface configuration register
`timescale 1ns/10ps
`default_nettype none
`include "pmi_defines.vh"

module pmi_xmii_cfg
#(
  parameter STRAPPED = 0
)
(
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  input  wire       speed_strap_i,
  input  wire       role_strap_i,
  input  wire [1:0] type_strap_i,
  output reg        speed_reg,
  output reg        rxdly_reg,
  output reg        txdly_reg,
  output reg        role_reg,
  output reg  [1:0] type_reg,
  output wire [7:0] rd_o
);

  // Synchronous reset: strapped copy samples its pins while reset is held
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      rxdly_reg <= `PMI_XC_RXDLY_RST;
      txdly_reg <= `PMI_XC_TXDLY_RST;
      if (STRAPPED != 0)
      begin
        speed_reg <= speed_strap_i;
        role_reg  <= role_strap_i;
        type_reg  <= type_strap_i;
      end
      else
      begin
        speed_reg <= `PMI_XC_P7_SPEED_RST;
        role_reg  <= `PMI_XC_P7_ROLE_RST;
        type_reg  <= `PMI_XC_P7_TYPE_RST;
      end
    end
    else if (wr_i)
    begin
      speed_reg <= wdata_i[`PMI_XC_SPEED_BIT];
      rxdly_reg <= wdata_i[`PMI_XC_RXDLY_BIT];
      txdly_reg <= wdata_i[`PMI_XC_TXDLY_BIT];
      role_reg  <= wdata_i[`PMI_XC_ROLE_BIT];
      type_reg  <= wdata_i[`PMI_XC_TYPE_MSB:`PMI_XC_TYPE_LSB];
    end
  end

  assign rd_o = {1'b0, speed_reg, 1'b0, rxdly_reg, txdly_reg, role_reg, type_reg};

endmodule // pmi_xmii_cfg

`default_nettype wire

// ### verif/pmi_cfg_props.sv
// Assertions for the port MAC and interface configuration block
`timescale 1ns/10ps
`default_nettype none
module pmi_cfg_props
(
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       reg_rd_i,
  input wire logic       reg_rvalid_o,
  input wire logic       if_rgmii_o,
  input wire logic       if_rmii_o,
  input wire logic       if_mii_o,
  input wire logic [1:0] link_speed_o,
  input wire logic       receive_clock_internal_delay_o,
  input wire logic       transmit_clock_internal_delay_o,
  input wire logic       mii_clk_drive_o,
  input wire logic       rxc_o,
  input wire logic       rxc_oe_o,
  input wire logic [6:0] full_duplex_i,
  input wire logic [6:0] back_pressure_o,
  input wire logic [6:0] rx_done_i,
  input wire logic [6:0] rx_is_fc_i,
  input wire logic       fc_filter_dis_i,
  input wire logic [6:0] rx_verdict_o,
  input wire logic [6:0] rx_drop_o,
  input wire logic [6:0] rx_mirror_only_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence rxc_rise_s;
    rxc_oe_o && $rose(rxc_o) ##1 rxc_oe_o;
  endsequence
  sequence rxc_fall_s;
    rxc_oe_o && $fell(rxc_o) ##1 rxc_oe_o [*2];
  endsequence
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  if_type_a: assert property ($past(rst_n_i) |-> $onehot({if_rgmii_o, if_rmii_o, if_mii_o})) else $error("type decode");
  gig_rgmii_a: assert property (link_speed_o == 2'h2 |-> if_rgmii_o) else $error("gigabit off RGMII");
  rx_delay_a: assert property (receive_clock_internal_delay_o |-> if_rgmii_o) else $error("rx delay");
  tx_delay_a: assert property (transmit_clock_internal_delay_o |-> if_rgmii_o) else $error("tx delay");
  phy_drive_a: assert property (mii_clk_drive_o |-> if_mii_o && !rxc_oe_o) else $error("clock role");
  rxc_idle_a: assert property (rxc_oe_o ? if_rmii_o : !rxc_o) else $error("rxc idle");
  rxc_high_a: assert property (rxc_rise_s |-> rxc_o ##1 !rxc_o) else $error("rxc high half");
  rxc_low_a: assert property (rxc_fall_s |-> rxc_o) else $error("rxc low half");
  bp_half_a: assert property ((back_pressure_o & $past(full_duplex_i)) == 7'h00) else $error("bp");
  verdict_pulse_a: assert property (rx_verdict_o == $past(rx_done_i)) else $error("verdict timing");
  verdict_excl_a: assert property ((rx_drop_o & rx_mirror_only_o) == 7'h00) else $error("drop and mirror");
  fc_filter_a: assert property (rx_done_i[0] && rx_is_fc_i[0] && !fc_filter_dis_i |=>
    rx_drop_o[0] && !rx_mirror_only_o[0]) else $error("fc frame not dropped");
endmodule // pmi_cfg_props
bind pmi_port_mac_if_cfg pmi_cfg_props u_props
(
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
  .if_rgmii_o(if_rgmii_o), .if_rmii_o(if_rmii_o), .if_mii_o(if_mii_o), .link_speed_o(link_speed_o),
  .receive_clock_internal_delay_o(receive_clock_internal_delay_o),
  .transmit_clock_internal_delay_o(transmit_clock_internal_delay_o), .mii_clk_drive_o(mii_clk_drive_o),
  .rxc_o(rxc_o), .rxc_oe_o(rxc_oe_o), .full_duplex_i(full_duplex_i), .back_pressure_o(back_pressure_o),
  .rx_done_i(rx_done_i), .rx_is_fc_i(rx_is_fc_i), .fc_filter_dis_i(fc_filter_dis_i),
  .rx_verdict_o(rx_verdict_o), .rx_drop_o(rx_drop_o), .rx_mirror_only_o(rx_mirror_only_o)
);
`default_nettype wire

// ### verif/pmi_far_end.sv
// Far-side RMII peer counting the reference clock the port drives
`timescale 1ns/10ps
`default_nettype none
module pmi_far_end
(
  input  wire logic       ref_clk_i,
  input  wire logic       rxc_i,
  input  wire logic       rxc_oe_i,
  output var  logic [7:0] edge_cnt_o
);
  logic last_rxc = 1'b0;
  initial edge_cnt_o = 8'h00;
  // Takes the clock only while the port acts as clock source
  always @(posedge ref_clk_i)
  begin
    if (rxc_oe_i && rxc_i != last_rxc)
      edge_cnt_o <= edge_cnt_o + 8'h01;
    last_rxc <= rxc_i;
  end
endmodule // pmi_far_end
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking testbench for the port MAC and interface configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sp = 1'b1, rl = 1'b0, s100 = 1'b0, fcd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wd = 8'h00, rdata, edges, e0;
  logic [1:0]  ty = 2'h1, spd;
  logic [6:0]  fd = 7'h00, done = 7'h00, crc = 7'h00, fc = 7'h00, storm, bp, verd, drop, mir;
  logic [97:0] len = 98'h0;
  logic        rvalid, rgm, rmi, mii, rxd, txd, drv, rxc, oe;
  int          n_fail = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  pmi_port_mac_if_cfg dut
  (
    .ref_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .speed_strap_pin_i(sp), .clock_role_strap_pin_i(rl),
    .interface_type_strap_pins_i(ty), .speed_100_i(s100), .if_rgmii_o(rgm), .if_rmii_o(rmi), .if_mii_o(mii),
    .link_speed_o(spd), .receive_clock_internal_delay_o(rxd), .transmit_clock_internal_delay_o(txd),
    .mii_clk_drive_o(drv), .rxc_o(rxc), .rxc_oe_o(oe), .full_duplex_i(fd), .storm_protect_o(storm),
    .back_pressure_o(bp), .rx_done_i(done), .rx_crc_err_i(crc), .rx_is_fc_i(fc), .rx_len_i(len),
    .fc_filter_dis_i(fcd), .rx_verdict_o(verd), .rx_drop_o(drop), .rx_mirror_only_o(mir)
  );
  pmi_far_end u_far (.ref_clk_i(clk), .rxc_i(rxc), .rxc_oe_i(oe), .edge_cnt_o(edges));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr_reg(input logic [3:0] p, input logic [11:0] off, input logic [7:0] d);
    @(posedge clk);
    addr <= {p, off};
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] p, input logic [11:0] off, input logic [7:0] exp);
    @(posedge clk);
    addr <= {p, off};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk1(rvalid, 1'b1);
    chk8(rdata, exp);
  endtask
  task automatic frame(input int p, input logic [13:0] l, input logic c, f, ed, em);
    @(posedge clk);
    done[p] <= 1'b1;
    crc[p] <= c;
    fc[p] <= f;
    len[14*p +: 14] <= l;
    @(posedge clk);
    done <= 7'h00;
    #1;
    chk1(verd[p], 1'b1);
    chk1(drop[p], ed);
    chk1(mir[p], em);
  endtask
  task automatic t_reset;
    rd_chk(4'h6, 12'h301, 8'h49);
    rd_chk(4'h7, 12'h301, 8'h08);
    rd_chk(4'h1, 12'h400, 8'h00);
    rd_chk(4'h7, 12'h401, 8'h00);
    chk1(rmi, 1'b1);
    e0 = edges;
    repeat (40) @(posedge clk);
    #1;
    chk8(edges - e0, 8'h14);
  endtask
  task automatic t_modes;
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(4'h6, 12'h301, 8'h18 | 8'(c));
      chk1(rgm, c == 0);
      chk1(rmi, c == 1);
      chk1(mii, c > 1);
      chk8({6'h00, spd}, (c == 0) ? 8'h02 : 8'h00);
      chk1(rxd, c == 0);
      chk1(txd, c == 0);
      chk1(drv, c > 1);
      chk1(oe, c == 1);
    end
    wr_reg(4'h6, 12'h301, 8'h06);
    chk1(drv, 1'b0);
    wr_reg(4'h6, 12'h301, 8'h05);
    chk1(oe, 1'b0);
    @(posedge clk) s100 <= 1'b1;
    wr_reg(4'h6, 12'h301, 8'h40);
    chk8({6'h00, spd}, 8'h01);
    chk1(txd, 1'b0);
    @(posedge clk) s100 <= 1'b0;
    wr_reg(4'h6, 12'h301, 8'h40);
    chk8({6'h00, spd}, 8'h00);
  endtask
  task automatic t_regs;
    wr_reg(4'h3, 12'h400, 8'hFF);
    rd_chk(4'h3, 12'h400, 8'h03);
    wr_reg(4'h3, 12'h401, 8'hFF);
    rd_chk(4'h3, 12'h401, 8'h09);
    rd_chk(4'h4, 12'h400, 8'h00);
    chk8({1'b0, storm}, 8'h04);
    chk1(bp[2], 1'b1);
    @(posedge clk) fd <= 7'h04;
    repeat (3) @(posedge clk);
    #1;
    chk1(bp[2], 1'b0);
    wr_reg(4'h3, 12'h301, 8'hFF);
    rd_chk(4'h3, 12'h301, 8'h00);
    wr_reg(4'h7, 12'h301, 8'hFF);
    rd_chk(4'h7, 12'h301, 8'h5F);
  endtask
  task automatic t_rx;
    wr_reg(4'h1, 12'h400, 8'h01);
    frame(0, 14'h2328, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(0, 14'h2329, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(0, 14'h0040, 1'b1, 1'b0, 1'b1, 1'b0);
    frame(0, 14'h002D, 1'b0, 1'b0, 1'b1, 1'b0);
    frame(0, 14'h0040, 1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge clk) fcd <= 1'b1;
    frame(0, 14'h0040, 1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk) fcd <= 1'b0;
    wr_reg(4'h1, 12'h401, 8'h01);
    frame(0, 14'h0040, 1'b1, 1'b0, 1'b0, 1'b1);
    frame(0, 14'h2329, 1'b0, 1'b0, 1'b0, 1'b1);
    frame(0, 14'h0040, 1'b0, 1'b1, 1'b1, 1'b0);
    frame(1, 14'h05DC, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(1, 14'h05DD, 1'b0, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_rst2;
    // Mid-run reset with other strap levels
    @(posedge clk);
    rst_n <= 1'b0;
    sp <= 1'b0;
    rl <= 1'b1;
    ty <= 2'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(4'h6, 12'h301, 8'h0C);
    rd_chk(4'h7, 12'h301, 8'h08);
    rd_chk(4'h3, 12'h400, 8'h00);
    rd_chk(4'h3, 12'h401, 8'h00);
    chk1(rgm, 1'b1);
    chk8({6'h00, spd}, 8'h02);
    chk1(rxd, 1'b0);
    chk1(txd, 1'b1);
    chk1(oe, 1'b0);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_regs();
    t_rx();
    t_rst2();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
